// [verilog/comparator_control_defines.vh]
// register map, field positions and codes for the comparator control block
// assumes word-aligned AHB-Lite access with the register index in haddr[7:2]
//
// What this block does
// - raw result is high when the chosen positive input exceeds the negative one.
// - comparator result is synchronised before it shows as read-only bit 5.
// - mux enabled and converter off: channel codes 0 to 7 pick the negative input.
// - mux disabled or converter on: dedicated negative pin drives the negative input.
// - mux-enable sits at bit 6 of converter control b.
// - bit 6 set picks the internal bandgap as positive input, else the pin.
// - writing one to bit 7 powers the comparator down, allowed any time.
// - mode bits 1:0 pick toggle, falling or rising edge; 01 is reserved.
// - hardware sets the flag at bit 4 on the selected synchronised event.
// - flag clears when its vector is taken or on a written one.
// - interrupt request only when flag, enable bit 3 and global enable are set.
// - bit 2 routes the comparator output to the timer capture front end.
// - a set input-buffer disable bit forces the matching port input bit to zero.
// - converter counts as on only while its enable bit is one.
`ifndef COMPARATOR_CONTROL_DEFINES_VH
`define COMPARATOR_CONTROL_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_INPUT_BUFFER_DISABLE 6'h01
`define IDX_COMPARATOR_CONTROL_STATUS 6'h08
`define IDX_CONVERTER_MUX_SELECT 6'h0C
`define IDX_CONVERTER_CONTROL_A 6'h0D
`define IDX_CONVERTER_CONTROL_B 6'h0E

// comparator control status fields
`define CCS_POWER_OFF 7
`define CCS_BANDGAP 6
`define CCS_RESULT 5
`define CCS_FLAG 4
`define CCS_INT_EN 3
`define CCS_CAPTURE 2
`define CCS_MODE_HI 1
`define CCS_MODE_LO 0

// converter register fields
`define CCA_CONVERTER_EN 7
`define CCB_MUX_EN 6
`define MUX_SEL_HI 4
`define MUX_SEL_LO 0
`define MUX_SEL_W 5
`define MUX_CHAN_MAX 5'h07

// event modes
`define MODE_TOGGLE 2'h0
`define MODE_RESERVED 2'h1
`define MODE_FALL 2'h2
`define MODE_RISE 2'h3

// ahb transfer type and response code
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000

`endif

// [verilog/level_sync.v]
// two-stage synchroniser for a group of independent levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/1ps
module level_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // levels
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  // first stage feeds only the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= {W{1'b0}};
      stable_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule // level_sync

// [verilog/comparator_control.v]
// comparator control: input selection, result sync, event flag, capture route
// assumes an analog comparator macro that returns a raw result level and takes
// the selection and power controls below; AHB-Lite slave, single master
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "comparator_control_defines.vh"
module comparator_control (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // analog comparator macro
  input wire comp_raw,
  output reg comparator_power_off,
  output reg bandgap_select,
  output reg neg_from_pin,
  output reg [7:0] neg_channel_sel,
  // cpu side
  input wire global_int_enable,
  input wire irq_ack,
  output reg irq,
  // timer capture front end
  output reg capture_route_enable,
  output reg capture_in,
  // port pins and their digital input buffers
  input wire [7:0] analog_channel_pins,
  output reg [7:0] input_buffer_off,
  output reg [7:0] port_in_value
);

  // software visible state
  reg [7:0] input_buffer_disable_r;
  reg [7:0] input_buffer_disable_nxt;
  reg power_off_r;
  reg power_off_nxt;
  reg bandgap_r;
  reg bandgap_nxt;
  reg flag_r;
  reg flag_nxt;
  reg int_en_r;
  reg int_en_nxt;
  reg capture_r;
  reg capture_nxt;
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg [`MUX_SEL_W-1:0] channel_select_r;
  reg [`MUX_SEL_W-1:0] channel_select_nxt;
  reg converter_enable_r;
  reg converter_enable_nxt;
  reg neg_input_mux_enable_r;
  reg neg_input_mux_enable_nxt;

  // bus data phase state
  reg wr_pend_r;
  reg [5:0] wr_idx_r;

  // comparator result path
  reg result_prev_r;
  wire result_sync;
  wire [7:0] pins_sync;
  wire comp_gated;
  reg event_hit;
  wire addr_ok;
  wire wr_ccs;
  wire [5:0] rd_idx;
  reg [7:0] rd_byte;
  reg [7:0] ccs_view;
  wire mux_active;

  // a powered-down comparator gives no valid answer; hold it low
  assign comp_gated = comp_raw & ~power_off_r;

  // result crosses into hclk before anyone looks at it
  level_sync #(
    .W(1)
  ) u_result_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(comp_gated),
    .sync_out(result_sync)
  );

  // port pins cross the same way
  level_sync #(
    .W(8)
  ) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(analog_channel_pins),
    .sync_out(pins_sync)
  );

  // event detection against the previous synchronised value
  always @* begin
    case (mode_r)
      `MODE_TOGGLE: event_hit = result_sync ^ result_prev_r;
      `MODE_FALL: event_hit = result_prev_r & ~result_sync;
      `MODE_RISE: event_hit = ~result_prev_r & result_sync;
      default: event_hit = 1'b0; // reserved code raises nothing
    endcase
  end

  // address phase decode; only accepted when the bus is ready
  assign addr_ok = hsel & hready & (htrans == `HTRANS_NONSEQ);
  assign rd_idx = haddr[7:2];
  assign wr_ccs = wr_pend_r & (wr_idx_r == `IDX_COMPARATOR_CONTROL_STATUS);

  // next state of every software register, including the write in data phase
  always @* begin
    input_buffer_disable_nxt = input_buffer_disable_r;
    power_off_nxt = power_off_r;
    bandgap_nxt = bandgap_r;
    int_en_nxt = int_en_r;
    capture_nxt = capture_r;
    mode_nxt = mode_r;
    channel_select_nxt = channel_select_r;
    converter_enable_nxt = converter_enable_r;
    neg_input_mux_enable_nxt = neg_input_mux_enable_r;
    if (wr_pend_r) begin
      case (wr_idx_r)
        `IDX_INPUT_BUFFER_DISABLE: input_buffer_disable_nxt = hwdata[7:0];
        `IDX_COMPARATOR_CONTROL_STATUS: begin
          power_off_nxt = hwdata[`CCS_POWER_OFF];
          bandgap_nxt = hwdata[`CCS_BANDGAP];
          int_en_nxt = hwdata[`CCS_INT_EN];
          capture_nxt = hwdata[`CCS_CAPTURE];
          mode_nxt = hwdata[`CCS_MODE_HI:`CCS_MODE_LO];
        end
        `IDX_CONVERTER_MUX_SELECT: channel_select_nxt = hwdata[`MUX_SEL_HI:`MUX_SEL_LO];
        `IDX_CONVERTER_CONTROL_A: converter_enable_nxt = hwdata[`CCA_CONVERTER_EN];
        `IDX_CONVERTER_CONTROL_B: neg_input_mux_enable_nxt = hwdata[`CCB_MUX_EN];
        default: ;
      endcase
    end
    // flag: a fresh event beats a clear in the same cycle
    flag_nxt = flag_r;
    if (irq_ack | (wr_ccs & hwdata[`CCS_FLAG])) begin
      flag_nxt = 1'b0;
    end
    if (event_hit) begin
      flag_nxt = 1'b1;
    end
  end

  // read view of the status register, built from next state so a read right
  // after a write sees the written value
  always @* begin
    ccs_view = `RST_BYTE;
    ccs_view[`CCS_POWER_OFF] = power_off_nxt;
    ccs_view[`CCS_BANDGAP] = bandgap_nxt;
    ccs_view[`CCS_RESULT] = result_sync;
    ccs_view[`CCS_FLAG] = flag_nxt;
    ccs_view[`CCS_INT_EN] = int_en_nxt;
    ccs_view[`CCS_CAPTURE] = capture_nxt;
    ccs_view[`CCS_MODE_HI:`CCS_MODE_LO] = mode_nxt;
  end

  // read mux; unmapped words read zero
  always @* begin
    rd_byte = `RST_BYTE;
    case (rd_idx)
      `IDX_INPUT_BUFFER_DISABLE: rd_byte = input_buffer_disable_nxt;
      `IDX_COMPARATOR_CONTROL_STATUS: rd_byte = ccs_view;
      `IDX_CONVERTER_MUX_SELECT: rd_byte[`MUX_SEL_HI:`MUX_SEL_LO] = channel_select_nxt;
      `IDX_CONVERTER_CONTROL_A: rd_byte[`CCA_CONVERTER_EN] = converter_enable_nxt;
      `IDX_CONVERTER_CONTROL_B: rd_byte[`CCB_MUX_EN] = neg_input_mux_enable_nxt;
      default: rd_byte = `RST_BYTE;
    endcase
  end

  // the multiplexer may be borrowed only while the converter is off
  assign mux_active = neg_input_mux_enable_nxt & ~converter_enable_nxt
    & (channel_select_nxt <= `MUX_CHAN_MAX);

  // bus slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      wr_pend_r <= addr_ok & hwrite;
      wr_idx_r <= rd_idx;
      if (addr_ok & ~hwrite) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // control and status registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_buffer_disable_r <= `RST_BYTE;
      power_off_r <= 1'b0;
      bandgap_r <= 1'b0;
      flag_r <= 1'b0;
      int_en_r <= 1'b0;
      capture_r <= 1'b0;
      mode_r <= `MODE_TOGGLE;
      channel_select_r <= {`MUX_SEL_W{1'b0}};
      converter_enable_r <= 1'b0;
      neg_input_mux_enable_r <= 1'b0;
      result_prev_r <= 1'b0;
    end else begin
      input_buffer_disable_r <= input_buffer_disable_nxt;
      power_off_r <= power_off_nxt;
      bandgap_r <= bandgap_nxt;
      flag_r <= flag_nxt;
      int_en_r <= int_en_nxt;
      capture_r <= capture_nxt;
      mode_r <= mode_nxt;
      channel_select_r <= channel_select_nxt;
      converter_enable_r <= converter_enable_nxt;
      neg_input_mux_enable_r <= neg_input_mux_enable_nxt;
      result_prev_r <= result_sync;
    end
  end

  // outputs, each from its own flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      comparator_power_off <= 1'b0;
      bandgap_select <= 1'b0;
      neg_from_pin <= 1'b1;
      neg_channel_sel <= `RST_BYTE;
      capture_route_enable <= 1'b0;
      capture_in <= 1'b0;
      input_buffer_off <= `RST_BYTE;
      port_in_value <= `RST_BYTE;
    end else begin
      irq <= flag_nxt & int_en_nxt & global_int_enable;
      comparator_power_off <= power_off_nxt;
      bandgap_select <= bandgap_nxt;
      neg_from_pin <= ~mux_active;
      // one-hot channel pick; all zero whenever the pin is used
      neg_channel_sel <= mux_active ? (8'h01 << channel_select_nxt[2:0]) : `RST_BYTE;
      capture_route_enable <= capture_nxt;
      capture_in <= capture_nxt & result_sync;
      input_buffer_off <= input_buffer_disable_nxt;
      port_in_value <= pins_sync & ~input_buffer_disable_nxt;
    end
  end

endmodule // comparator_control

// [tb/comparator_partner.sv]
// behavioural analog front end: picks inputs from the selections, compares them
// assumes voltages in millivolts driven by the bench; channel pin n sits at n*CH_STEP
`timescale 1ns/1ps
module comparator_partner #(
  parameter int BG_MV = 200,
  parameter int CH_STEP = 40
) (
  // selections from the block
  input wire bandgap_select,
  input wire neg_from_pin,
  input wire [7:0] neg_channel_sel,
  // pin levels from the bench
  input int pos_mv,
  input int neg_mv,
  // raw result
  output logic comp_raw
);
  int p;
  int n;
  // idle channel mux leaves the negative node at the pin level, never floating
  always_comb begin
    p = bandgap_select ? BG_MV : pos_mv;
    n = neg_mv;
    for (int i = 0; i < 8; i++) begin
      if (!neg_from_pin && neg_channel_sel[i]) begin
        n = i * CH_STEP;
      end
    end
    comp_raw = p > n;
  end
endmodule // comparator_partner

// [tb/comparator_control_props.sv]
// port relations of the comparator control block
// assumes binding to comparator_control, single clock hclk
`timescale 1ns/1ps
module comparator_control_props (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // watched ports
  input wire global_int_enable,
  input wire irq,
  input wire capture_route_enable,
  input wire capture_in,
  input wire comparator_power_off,
  input wire neg_from_pin,
  input wire [7:0] neg_channel_sel,
  input wire [7:0] input_buffer_off,
  input wire [7:0] port_in_value
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // four cycles flush meta, sync and capture stages
  sequence s_off; comparator_power_off [*4]; endsequence
  sequence s_unrouted; !capture_route_enable [*2]; endsequence
  property p_irq_gie; irq |-> $past(global_int_enable); endproperty
  property p_irq_drop; !global_int_enable |=> !irq; endproperty
  property p_cap; capture_in |-> capture_route_enable || $past(capture_route_enable); endproperty
  property p_cap_off; s_unrouted |-> !capture_in; endproperty
  property p_pin_neg; neg_from_pin |-> neg_channel_sel == 8'h00; endproperty
  property p_onehot; !neg_from_pin |-> $onehot(neg_channel_sel); endproperty
  property p_buf_mask;
    (port_in_value & input_buffer_off & $past(input_buffer_off)) == 8'h00;
  endproperty
  property p_power_gate; s_off |-> !capture_in; endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept after disable");
  a_cap: assert property (p_cap) else $error("capture without route");
  a_cap_off: assert property (p_cap_off) else $error("capture while unrouted");
  a_pin_neg: assert property (p_pin_neg) else $error("channel with pin selected");
  a_onehot: assert property (p_onehot) else $error("channel select not one-hot");
  a_buf_mask: assert property (p_buf_mask) else $error("disabled pin reads one");
  a_power_gate: assert property (p_power_gate) else $error("result while off");
endmodule // comparator_control_props

// [tb/comparator_control_test.sv]
// self-checking bench for the comparator control block
// assumes one AHB-Lite master, zero-wait slave, partner model on the analog side
`timescale 1ns/1ps
module comparator_control_test;
  logic hclk, hresetn, hsel, hwrite, gie, irq_ack;
  logic [7:0] haddr, pins;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rdv;
  logic hreadyout, hresp, comp_raw, cpo, bgs, nfp, irq, cre, capture_in;
  logic [7:0] ncs, ibo, port_in_value, r;
  int pos_mv, err_count, n_tests;
  // expected result, expected one-hot channel (zero: pin), then mux, conv, bg, code
  logic [16:0] rows [13] = '{17'h10180, 17'h10281, 17'h10482, 17'h00883, 17'h01084,
    17'h02085, 17'h04086, 17'h08087, 17'h000C0, 17'h00001, 17'h108A3, 17'h10020, 17'h100AF};
  logic [16:0] rw;
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  comparator_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_raw(comp_raw),
    .comparator_power_off(cpo), .bandgap_select(bgs), .neg_from_pin(nfp),
    .neg_channel_sel(ncs), .global_int_enable(gie), .irq_ack(irq_ack), .irq(irq),
    .capture_route_enable(cre), .capture_in(capture_in), .analog_channel_pins(pins),
    .input_buffer_off(ibo), .port_in_value(port_in_value));
  comparator_partner u_ana (.bandgap_select(bgs), .neg_from_pin(nfp), .neg_channel_sel(ncs),
    .pos_mv(pos_mv), .neg_mv(150), .comp_raw(comp_raw));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic edge_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    edge_rdy();
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; gie = 1'b0; irq_ack = 1'b0; pins = 8'hFF; pos_mv = 100;
    err_count = 0; n_tests = 0;
    cyc(4);
    hresetn <= 1'b1;
    cyc(1);
    ahb(0, 8'h04, 0, rdv); chk("buf_reset", 0, rdv);
    ahb(0, 8'h20, 0, rdv); chk("ccs_reset", 0, rdv & 32'hDF);
    ahb(1, 8'h3C, 32'hFF, rdv); ahb(0, 8'h3C, 0, rdv); chk("unmapped", 0, rdv);
    ahb(1, 8'h04, 32'h06, rdv); cyc(4);
    chk("port_in", 8'hF9, port_in_value);
    chk("buffer_off", 8'h06, ibo);
    chk("hresp", 0, hresp);
    // input selection rows
    for (int i = 0; i < 13; i++) begin
      rw = rows[i];
      r = rw[7:0];
      ahb(1, 8'h38, {25'h0, r[7], 6'h0}, rdv);
      ahb(1, 8'h34, {24'h0, r[6], 7'h0}, rdv);
      ahb(1, 8'h30, {27'h0, r[4:0]}, rdv);
      ahb(1, 8'h20, {25'h0, r[5], 6'h0}, rdv);
      cyc(5);
      chk("neg_from_pin", rw[15:8] == 8'h00, nfp);
      chk("neg_channel_sel", rw[15:8], ncs);
      chk("bandgap_select", r[5], bgs);
      ahb(0, 8'h20, 0, rdv);
      chk("result", rw[16], rdv[5]);
      ahb(0, 8'h30, 0, rdv);
      chk("channel_readback", r[4:0], rdv);
    end
    // mux off and bandgap off, result settles low before the mode loop
    ahb(1, 8'h38, 0, rdv);
    ahb(1, 8'h20, 0, rdv); cyc(5);
    // every event mode, interrupt held off while the mode changes
    for (int m = 0; m < 4; m++) begin
      pos_mv <= 100; cyc(5); ahb(1, 8'h20, 32'h10 | m, rdv);
      pos_mv <= 200; cyc(5); ahb(0, 8'h20, 0, rdv);
      chk("rise_flag", m == 0 || m == 3, rdv[4]);
      ahb(1, 8'h20, 32'h10 | m, rdv);
      pos_mv <= 100; cyc(5); ahb(0, 8'h20, 0, rdv);
      chk("fall_flag", m == 0 || m == 2, rdv[4]);
    end
    gie <= 1'b1; ahb(1, 8'h20, 32'h1B, rdv);
    pos_mv <= 200; cyc(5); chk("irq_on", 1, irq);
    gie <= 1'b0; cyc(2); chk("irq_gie", 0, irq);
    irq_ack <= 1'b1; cyc(1); irq_ack <= 1'b0; cyc(1);
    ahb(0, 8'h20, 0, rdv); chk("flag_ack", 0, rdv[4]);
    ahb(1, 8'h20, 32'h04, rdv); cyc(5); chk("capture_in", 1, capture_in);
    chk("capture_route", 1, cre);
    ahb(1, 8'h20, 32'h84, rdv);
    cyc(5); chk("capture_off", 0, capture_in);
    chk("power_off", 1, cpo);
    // flag set by the power-off fall; a written zero keeps it, a one clears it
    ahb(1, 8'h20, 32'h80, rdv); ahb(0, 8'h20, 0, rdv);
    chk("flag_keep", 32'h90, rdv & 32'hFF);
    ahb(1, 8'h20, 32'h90, rdv); ahb(0, 8'h20, 0, rdv);
    chk("flag_w1c", 32'h80, rdv & 32'hFF);
    // reset in mid-run; result held low so no edge follows release
    pos_mv <= 100; hresetn <= 1'b0; cyc(2);
    chk("rst_pin", 1, nfp);
    chk("rst_buf_off", 0, ibo);
    chk("rst_power", 0, cpo);
    hresetn <= 1'b1; cyc(1);
    ahb(0, 8'h20, 0, rdv); chk("ccs_rst2", 0, rdv & 32'hDF);
    ahb(0, 8'h04, 0, rdv); chk("buf_rst2", 0, rdv);
    summarize();
  end
endmodule // comparator_control_test
bind comparator_control comparator_control_props u_props (.hclk(hclk), .hresetn(hresetn),
  .global_int_enable(global_int_enable), .irq(irq), .capture_route_enable(capture_route_enable),
  .capture_in(capture_in), .comparator_power_off(comparator_power_off),
  .neg_from_pin(neg_from_pin), .neg_channel_sel(neg_channel_sel),
  .input_buffer_off(input_buffer_off), .port_in_value(port_in_value));
